//--- rtl/ifd_decode.v
/*
 * Field decoder: operands, load/store address,
 * space tags, alignment, big-endian lanes.
 * Assumes fetch, write-back and condition logic
 * on this clock; register reads answer next cycle.
 */
`timescale 1ns/10ps
`include "ifd_regs.vh"
// What this block does
// - destination field also names store data register
// - annul bit suppresses delay slot per branch kind
// - four-bit condition selector chosen for branches
// - set-upper puts 22-bit constant high
// - call/branch offsets sign-extended word displacements
// - format-3 function from six bits plus format bit
// - operand two is register or sign-extended immediate
// - alternate-space accesses use instruction space field
// - five-bit first source index
// - nine-bit operate code for coprocessor/float ops
// - address is register plus register or immediate
// - integer sizes 8-64, float/coprocessor word/dword
// - half, word, dword need natural alignment
// - misaligned access traps instead of completing
// - byte lanes big-endian, offset zero highest
// - halfword offset zero selects upper half
// - doubleword high word at offset zero
// - data space tag user 0x0A, supervisor 0x0B
// - fetch space tag user 0x08, supervisor 0x09
// - arithmetic reads first source, writes or discards
// - register zero reads zero, ignores writes
// - format selector decodes call/branch/memory/arithmetic
// - branch sub code decodes branch kinds
// - set-upper clears low ten bits
// - relative target is pc plus shifted displacement
module ifd_decode (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_instr_valid,
    input wire [31:0] i_instr,
    input wire [31:0] i_pc,
    input wire i_cond_true,
    input wire i_wb_en,
    input wire [4:0] i_wb_idx,
    input wire [31:0] i_wb_data,
    input wire [3:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    input wire i_reg_we,
    input wire i_reg_re,
    output reg [31:0] o_reg_rdata,
    output reg o_dec_valid,
    output reg [1:0] o_format_sel,
    output reg [2:0] o_fmt2_sub_code,
    output reg [6:0] o_fmt3_func_code,
    output reg [8:0] o_operate_code,
    output reg [4:0] o_rd_index,
    output reg [4:0] o_src_one_index,
    output reg [4:0] o_src_two_index,
    output reg [3:0] o_branch_cond,
    output reg o_is_call,
    output reg o_is_int_branch,
    output reg o_is_float_branch,
    output reg o_is_cop_branch,
    output reg o_is_set_upper,
    output reg o_is_unimpl_trap,
    output reg o_is_undefined,
    output reg o_is_alu,
    output reg o_is_mem,
    output reg o_annul_next,
    output reg o_rd_write,
    output reg [31:0] o_operand_a,
    output reg [31:0] o_operand_b,
    output reg [31:0] o_set_upper_value,
    output reg [31:0] o_target,
    output reg o_mem_req,
    output reg o_mem_we,
    output reg [31:0] o_mem_addr,
    output reg [7:0] o_mem_asi,
    output reg [7:0] o_mem_byte_en,
    output reg [63:0] o_mem_wdata,
    output reg o_misalign_trap,
    output reg o_priv_trap,
    output reg o_fetch_misalign,
    output reg [7:0] o_fetch_asi
);
    reg [31:0] instr_r;
    reg [31:0] pc_r;
    reg valid_r;
    reg [1:0] ctrl_r;
    reg [3:0] stat_r;
    reg [15:0] tcnt_r;
    reg [15:0] tcnt_nxt;

    wire super_mode = ctrl_r[`IFD_CTRL_SUPER];
    wire dec_en = ctrl_r[`IFD_CTRL_EN];

    // fields straight from the held word, no logic in between
    wire [1:0] format_sel = instr_r[`IFD_F_FMT];
    wire [4:0] rd_index = instr_r[`IFD_F_RD];
    wire annul_bit = instr_r[`IFD_F_ANNUL];
    wire [3:0] branch_cond = instr_r[`IFD_F_COND];
    wire [2:0] fmt2_sub_code = instr_r[`IFD_F_SUB];
    wire [21:0] upper_const_field = instr_r[`IFD_F_UPPER];
    wire [21:0] branch_offset = instr_r[`IFD_F_BOFS];
    wire [29:0] call_offset = instr_r[`IFD_F_COFS];
    wire [5:0] func6 = instr_r[`IFD_F_FUNC];
    wire [4:0] src_one_index = instr_r[`IFD_F_RS1];
    wire imm_sel = instr_r[`IFD_F_ISEL];
    wire [7:0] asi_field = instr_r[`IFD_F_ASI];
    wire [12:0] short_imm_field = instr_r[`IFD_F_SIMM];
    wire [8:0] operate_code = instr_r[`IFD_F_OPF];
    wire [4:0] src_two_index = instr_r[`IFD_F_RS2];

    // major format and branch-format sub decode
    wire is_br_fmt = (format_sel == `IFD_FMT_BR);
    wire is_call = (format_sel == `IFD_FMT_CALL);
    wire is_alu = (format_sel == `IFD_FMT_ALU);
    wire is_mem = (format_sel == `IFD_FMT_MEM);
    wire is_unimpl_trap = is_br_fmt && (fmt2_sub_code == `IFD_SUB_UNIMPL_TRAP_INSTR);
    wire is_int_branch = is_br_fmt && (fmt2_sub_code == `IFD_SUB_IBR);
    wire is_set_upper = is_br_fmt && (fmt2_sub_code == `IFD_SUB_SETUP);
    wire is_float_branch = is_br_fmt && (fmt2_sub_code == `IFD_SUB_FBR);
    wire is_cop_branch = is_br_fmt && (fmt2_sub_code == `IFD_SUB_CBR);
    wire is_undefined = is_br_fmt && fmt2_sub_code[0] && (fmt2_sub_code != `IFD_SUB_CBR);
    wire is_branch = is_int_branch || is_float_branch || is_cop_branch;

    // format-3 function keeps the low format bit to split alu from memory
    wire [6:0] fmt3_func_code = {format_sel[0], func6};

    // register reads; store pair is rd, rd|1
    wire [31:0] ra_data;
    wire [31:0] rb_data;
    wire [31:0] rc_data;
    wire [31:0] rd_pair_data;
    wire [4:0] rd_odd_index = {rd_index[4:1], 1'b1};

    ifd_regfile #(
        .W(32),
        .AW(5)
    ) u_regs (
        .i_clk(i_clk),
        .i_we(i_wb_en),
        .i_widx(i_wb_idx),
        .i_wdata(i_wb_data),
        .i_ra_idx(src_one_index),
        .i_rb_idx(src_two_index),
        .i_rc_idx(rd_index),
        .o_ra_data(ra_data),
        .o_rb_data(rb_data),
        .o_rc_data(rc_data)
    );

    // odd half of a store pair
    ifd_regfile #(
        .W(32),
        .AW(5)
    ) u_regs_odd (
        .i_clk(i_clk),
        .i_we(i_wb_en),
        .i_widx(i_wb_idx),
        .i_wdata(i_wb_data),
        .i_ra_idx(rd_odd_index),
        .i_rb_idx(5'h00),
        .i_rc_idx(5'h00),
        .o_ra_data(rd_pair_data),
        .o_rb_data(),
        .o_rc_data()
    );

    // operand select and effective address
    wire [31:0] simm_ext = {{19{short_imm_field[12]}}, short_imm_field};
    wire [31:0] operand_b = imm_sel ? simm_ext : rb_data;
    wire [31:0] eff_addr = ra_data + operand_b;

    // pc-relative targets, displacement counted in words
    wire [31:0] call_disp = {call_offset, 2'h0};
    wire [31:0] br_disp = {{8{branch_offset[21]}}, branch_offset, 2'h0};
    wire [31:0] target = pc_r + (is_call ? call_disp : br_disp);

    // set-upper constant goes high, low ten bits forced clear
    wire [31:0] set_upper_value = {upper_const_field, 10'h000};

    // memory access size; float and coprocessor only move words or pairs
    wire is_fc_mem = func6[5];
    wire is_store = func6[2];
    wire is_alt = !func6[5] && func6[4];
    reg [1:0] acc_size;

    always @* begin
        acc_size = func6[1:0];
        if (is_fc_mem && (func6[1:0] != `IFD_SZ_DWORD)) begin
            acc_size = `IFD_SZ_WORD;
        end
    end

    // store data right-justified; a pair puts register rd first, then rd|1
    wire [63:0] st_data = (acc_size == `IFD_SZ_DWORD) ? {rc_data, rd_pair_data} : {32'h0, rc_data};

    wire [63:0] lanes;
    wire [7:0] byte_en;
    wire misalign;

    ifd_lane u_lane (
        .i_size(acc_size),
        .i_ofs(eff_addr[2:0]),
        .i_data(st_data),
        .o_lanes(lanes),
        .o_be(byte_en),
        .o_misalign(misalign)
    );

    // space tag: alternate form takes it from the word in either mode; in user mode it traps
    wire [7:0] data_asi = is_alt ? asi_field : (super_mode ? `IFD_ASI_SDATA : `IFD_ASI_UDATA);
    wire priv_fault = is_mem && is_alt && !super_mode;
    wire mis_fault = is_mem && misalign;
    wire fetch_mis = (pc_r[1:0] != 2'h0);

    // a taken conditional branch keeps its slot;
    // never-branch with the bit annuls too
    wire uncond = (branch_cond[2:0] == 3'h0);
    wire annul_next = is_branch && annul_bit && !(!uncond && i_cond_true);

    // writes to the destination; index zero discards the result
    wire writes_rd = is_alu || is_set_upper || is_call || (is_mem && !is_store);
    wire rd_write = writes_rd && (rd_index != 5'h00);

    wire dec_fire = valid_r && dec_en;
    wire any_trap = dec_fire && (priv_fault || mis_fault || fetch_mis);

    // instruction holding stage; decode reads only this word
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            instr_r <= 32'h00000000;
            pc_r <= 32'h00000000;
            valid_r <= 1'b0;
        end else begin
            valid_r <= i_instr_valid && dec_en;
            if (i_instr_valid && dec_en) begin
                instr_r <= i_instr;
                pc_r <= i_pc;
            end
        end
    end

    // decoded fields, operands and access, all held one cycle
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dec_valid <= 1'b0;
            o_format_sel <= 2'h0;
            o_fmt2_sub_code <= 3'h0;
            o_fmt3_func_code <= 7'h00;
            o_operate_code <= 9'h000;
            o_rd_index <= 5'h00;
            o_src_one_index <= 5'h00;
            o_src_two_index <= 5'h00;
            o_branch_cond <= 4'h0;
            o_is_call <= 1'b0;
            o_is_int_branch <= 1'b0;
            o_is_float_branch <= 1'b0;
            o_is_cop_branch <= 1'b0;
            o_is_set_upper <= 1'b0;
            o_is_unimpl_trap <= 1'b0;
            o_is_undefined <= 1'b0;
            o_is_alu <= 1'b0;
            o_is_mem <= 1'b0;
            o_annul_next <= 1'b0;
            o_rd_write <= 1'b0;
            o_operand_a <= 32'h00000000;
            o_operand_b <= 32'h00000000;
            o_set_upper_value <= 32'h00000000;
            o_target <= 32'h00000000;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 32'h00000000;
            o_mem_asi <= 8'h00;
            o_mem_byte_en <= 8'h00;
            o_mem_wdata <= 64'h0000000000000000;
            o_misalign_trap <= 1'b0;
            o_priv_trap <= 1'b0;
            o_fetch_misalign <= 1'b0;
        end else begin
            o_dec_valid <= dec_fire;
            o_format_sel <= format_sel;
            o_fmt2_sub_code <= fmt2_sub_code;
            o_fmt3_func_code <= fmt3_func_code;
            o_operate_code <= operate_code;
            o_rd_index <= rd_index;
            o_src_one_index <= src_one_index;
            o_src_two_index <= src_two_index;
            o_branch_cond <= branch_cond;
            o_is_call <= dec_fire && is_call;
            o_is_int_branch <= dec_fire && is_int_branch;
            o_is_float_branch <= dec_fire && is_float_branch;
            o_is_cop_branch <= dec_fire && is_cop_branch;
            o_is_set_upper <= dec_fire && is_set_upper;
            o_is_unimpl_trap <= dec_fire && is_unimpl_trap;
            o_is_undefined <= dec_fire && is_undefined;
            o_is_alu <= dec_fire && is_alu;
            o_is_mem <= dec_fire && is_mem;
            o_annul_next <= dec_fire && annul_next;
            o_rd_write <= dec_fire && rd_write;
            o_operand_a <= ra_data;
            o_operand_b <= operand_b;
            o_set_upper_value <= set_upper_value;
            o_target <= target;
            // a faulting access never reaches memory
            o_mem_req <= dec_fire && is_mem && !misalign && !priv_fault && !fetch_mis;
            o_mem_we <= dec_fire && is_mem && is_store && !misalign && !priv_fault && !fetch_mis;
            o_mem_addr <= eff_addr;
            o_mem_asi <= data_asi;
            o_mem_byte_en <= (dec_fire && is_mem && !misalign) ? byte_en : 8'h00;
            o_mem_wdata <= lanes;
            o_misalign_trap <= dec_fire && mis_fault;
            o_priv_trap <= dec_fire && priv_fault;
            o_fetch_misalign <= dec_fire && fetch_mis;
        end
    end

    // fetch tag follows the mode bit directly
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_fetch_asi <= `IFD_ASI_UINSTR;
        end else begin
            o_fetch_asi <= super_mode ? `IFD_ASI_SINSTR : `IFD_ASI_UINSTR;
        end
    end

    // trap counter: a new trap in the clearing cycle still counts
    always @* begin
        tcnt_nxt = tcnt_r;
        if (i_reg_we && (i_reg_addr == `IFD_OFS_TCNT)) begin
            tcnt_nxt = 16'h0000;
        end
        if (any_trap) begin
            tcnt_nxt = tcnt_nxt + 16'h0001;
        end
    end

    // control, status and counter registers
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_r <= `IFD_CTRL_RST;
            stat_r <= 4'h0;
            tcnt_r <= 16'h0000;
        end else begin
            tcnt_r <= tcnt_nxt;
            if (i_reg_we && (i_reg_addr == `IFD_OFS_CTRL)) begin
                ctrl_r <= i_reg_wdata[1:0];
            end
            if (dec_fire) begin
                stat_r <= {priv_fault, mis_fault, annul_next, fetch_mis};
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_reg_re) begin
            case (i_reg_addr)
                `IFD_OFS_CTRL: o_reg_rdata <= {30'h0, ctrl_r};
                `IFD_OFS_STAT: o_reg_rdata <= {28'h0, stat_r};
                `IFD_OFS_LAST: o_reg_rdata <= instr_r;
                `IFD_OFS_TCNT: o_reg_rdata <= {16'h0, tcnt_r};
                default: o_reg_rdata <= 32'h00000000;
            endcase
        end else begin
            o_reg_rdata <= 32'h00000000;
        end
    end
endmodule

//--- rtl/ifd_regs.vh
/* Field decoder constants; included by bare name. */
`ifndef IFD_REGS_VH
`define IFD_REGS_VH

// register offsets on the plain register port
`define IFD_OFS_CTRL 4'h0
`define IFD_OFS_STAT 4'h4
`define IFD_OFS_LAST 4'h8
`define IFD_OFS_TCNT 4'hC

// control bits and reset value
`define IFD_CTRL_SUPER 0
`define IFD_CTRL_EN 1
`define IFD_CTRL_RST 2'h2

// instruction field positions
`define IFD_F_FMT 31:30
`define IFD_F_RD 29:25
`define IFD_F_ANNUL 29
`define IFD_F_COND 28:25
`define IFD_F_SUB 24:22
`define IFD_F_UPPER 21:0
`define IFD_F_BOFS 21:0
`define IFD_F_COFS 29:0
`define IFD_F_FUNC 24:19
`define IFD_F_RS1 18:14
`define IFD_F_ISEL 13
`define IFD_F_ASI 12:5
`define IFD_F_SIMM 12:0
`define IFD_F_OPF 13:5
`define IFD_F_RS2 4:0

// major format selector values
`define IFD_FMT_BR 2'h0
`define IFD_FMT_CALL 2'h1
`define IFD_FMT_ALU 2'h2
`define IFD_FMT_MEM 2'h3

// branch format sub codes
`define IFD_SUB_UNIMPL_TRAP_INSTR 3'h0
`define IFD_SUB_IBR 3'h2
`define IFD_SUB_SETUP 3'h4
`define IFD_SUB_FBR 3'h6
`define IFD_SUB_CBR 3'h7

// access size codes from the low function bits
`define IFD_SZ_WORD 2'h0
`define IFD_SZ_BYTE 2'h1
`define IFD_SZ_HALF 2'h2
`define IFD_SZ_DWORD 2'h3

// address space tags
`define IFD_ASI_UINSTR 8'h08
`define IFD_ASI_SINSTR 8'h09
`define IFD_ASI_UDATA 8'h0A
`define IFD_ASI_SDATA 8'h0B

`endif

//--- rtl/ifd_regfile.v
/*
 * Register file, three read ports, one write port.
 * Assumes same-clock writes; reads combinational.
 */
`timescale 1ns/10ps
module ifd_regfile #(
    parameter W = 32,
    parameter AW = 5
) (
    input wire i_clk,
    input wire i_we,
    input wire [AW-1:0] i_widx,
    input wire [W-1:0] i_wdata,
    input wire [AW-1:0] i_ra_idx,
    input wire [AW-1:0] i_rb_idx,
    input wire [AW-1:0] i_rc_idx,
    output wire [W-1:0] o_ra_data,
    output wire [W-1:0] o_rb_data,
    output wire [W-1:0] o_rc_data
);
    reg [W-1:0] mem_r [0:(1<<AW)-1];

    // entry zero is never written, so no reset is needed for it to stay clean
    always @(posedge i_clk) begin
        if (i_we && (i_widx != {AW{1'b0}})) begin
            mem_r[i_widx] <= i_wdata;
        end
    end

    // index zero reads as zero whatever the array holds
    assign o_ra_data = (i_ra_idx == {AW{1'b0}}) ? {W{1'b0}} : mem_r[i_ra_idx];
    assign o_rb_data = (i_rb_idx == {AW{1'b0}}) ? {W{1'b0}} : mem_r[i_rb_idx];
    assign o_rc_data = (i_rc_idx == {AW{1'b0}}) ? {W{1'b0}} : mem_r[i_rc_idx];
endmodule

//--- rtl/ifd_lane.v
/*
 * Big-endian lane steering on a 64-bit path.
 * Assumes right-justified data; lane 0 is 63:56.
 */
`timescale 1ns/10ps
`include "ifd_regs.vh"
module ifd_lane (
    input wire [1:0] i_size,
    input wire [2:0] i_ofs,
    input wire [63:0] i_data,
    output reg [63:0] o_lanes,
    output reg [7:0] o_be,
    output reg o_misalign
);
    reg [3:0] nb;
    reg [3:0] gap;
    reg [7:0] mask;
    reg [63:0] dmask;

    // lowest address holds the most significant byte
    always @* begin
        nb = 4'h4;
        mask = 8'h0F;
        dmask = 64'h00000000FFFFFFFF;
        o_misalign = (i_ofs[1:0] != 2'h0);
        case (i_size)
            `IFD_SZ_BYTE: begin
                nb = 4'h1;
                mask = 8'h01;
                dmask = 64'h00000000000000FF;
                o_misalign = 1'b0;
            end
            `IFD_SZ_HALF: begin
                nb = 4'h2;
                mask = 8'h03;
                dmask = 64'h000000000000FFFF;
                o_misalign = i_ofs[0];
            end
            `IFD_SZ_DWORD: begin
                nb = 4'h8;
                mask = 8'hFF;
                dmask = 64'hFFFFFFFFFFFFFFFF;
                o_misalign = (i_ofs != 3'h0);
            end
            default: nb = 4'h4;
        endcase
        gap = 4'h8 - nb - {1'b0, i_ofs};
        o_be = mask << gap[2:0];
        o_lanes = (i_data & dmask) << {gap[2:0], 3'h0};
    end
endmodule

//--- verif/ifd_checker.sv
/* Decoder port checker, fields traced to the word.
   Assumes bind into ifd_decode. */
`timescale 1ns/10ps
module ifd_checker (
    input wire i_clk,
    input wire i_rst_b,
    input wire [31:0] i_instr,
    input wire [31:0] i_pc,
    input wire i_instr_valid,
    input wire o_dec_valid,
    input wire [1:0] o_format_sel,
    input wire [6:0] o_fmt3_func_code,
    input wire [8:0] o_operate_code,
    input wire [4:0] o_rd_index,
    input wire [4:0] o_src_one_index,
    input wire [3:0] o_branch_cond,
    input wire o_is_call,
    input wire o_rd_write,
    input wire [31:0] o_operand_b,
    input wire [31:0] o_set_upper_value,
    input wire [31:0] o_target,
    input wire o_mem_req,
    input wire [7:0] o_mem_asi,
    input wire [7:0] o_mem_byte_en,
    input wire o_misalign_trap,
    input wire [7:0] o_fetch_asi
);
    reg [31:0] w1_r, w_r, p1_r, p_r;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // two-stage copy of word and pc, matching the decode latency
    always @(posedge i_clk) begin
        w1_r <= i_instr;
        w_r <= w1_r;
        p1_r <= i_pc;
        p_r <= p1_r;
    end
    lat_pulse_a: assert property (o_dec_valid |-> $past(i_instr_valid, 2)) else $error("decode without word");
    rd_field_a: assert property (o_dec_valid |-> o_rd_index == w_r[29:25]) else $error("rd index");
    cond_field_a: assert property (o_dec_valid |-> o_branch_cond == w_r[28:25]) else $error("cond field");
    upper_val_a: assert property (o_dec_valid |-> o_set_upper_value == {w_r[21:0], 10'h000})
        else $error("upper value");
    func_code_a: assert property (o_dec_valid |-> o_fmt3_func_code == {w_r[30], w_r[24:19]}) else $error("func");
    src_one_a: assert property (o_dec_valid |-> o_src_one_index == w_r[18:14]) else $error("src one");
    op_code_a: assert property (o_dec_valid |-> o_operate_code == w_r[13:5]) else $error("operate code");
    imm_opb_a: assert property (o_dec_valid && w_r[13] |-> o_operand_b == {{19{w_r[12]}}, w_r[12:0]})
        else $error("immediate operand");
    call_tgt_a: assert property (o_is_call |-> o_target == p_r + {w_r[29:0], 2'h0}) else $error("call target");
    fmt_sel_a: assert property (o_dec_valid |-> o_format_sel == w_r[31:30] && o_is_call == (w_r[31:30] == 2'h1))
        else $error("format select");
    trap_block_a: assert property (o_misalign_trap |-> !o_mem_req && o_mem_byte_en == 8'h00)
        else $error("misaligned access issued");
    alt_tag_a: assert property (o_mem_req && w_r[24:23] == 2'h1 |-> o_mem_asi == w_r[12:5]) else $error("alt tag");
    data_tag_a: assert property (o_mem_req && w_r[24:23] != 2'h1 |-> o_mem_asi[7:1] == 7'h05)
        else $error("data tag");
    fetch_tag_a: assert property (o_fetch_asi[7:1] == 7'h04) else $error("fetch tag");
    zero_dst_a: assert property (o_rd_write |-> o_rd_index != 5'h00) else $error("write to zero");
endmodule
bind ifd_decode ifd_checker u_chk (.*);

//--- verif/ifd_mem_model.sv
/* Data memory model, eight doublewords.
   Assumes enable bit 7 is offset 0. */
`timescale 1ns/10ps
module ifd_mem_model (
    input wire i_clk,
    input wire i_req,
    input wire i_we,
    input wire [31:0] i_addr,
    input wire [7:0] i_be,
    input wire [63:0] i_wdata,
    input wire [2:0] i_raddr,
    output wire [63:0] o_dword
);
    reg [63:0] mem_r [0:7];
    integer k;
    // enabled lanes only
    always @(posedge i_clk) begin
        if (i_req && i_we) begin
            for (k = 0; k < 8; k = k + 1) begin
                if (i_be[k]) begin
                    mem_r[i_addr[5:3]][8*k +: 8] <= i_wdata[8*k +: 8];
                end
            end
        end
    end
    assign o_dword = mem_r[i_raddr];
endmodule

//--- verif/instr_field_decode_ldst_addr_tb.sv
/* Field decoder bench, random and corner words.
   Assumes checker and memory model compiled. */
`timescale 1ns/10ps
`include "ifd_regs.vh"
`define CHK(n, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module instr_field_decode_ldst_addr_tb;
    reg i_clk = 1'h0, i_rst_b = 1'h0, i_instr_valid = 1'h0, i_cond_true = 1'h0;
    reg i_wb_en = 1'h0, i_reg_we = 1'h0, i_reg_re = 1'h0;
    reg [31:0] i_instr = 32'h0, i_pc = 32'h0, i_wb_data = 32'h0, i_reg_wdata = 32'h0, rv [0:7], w, a;
    reg [4:0] i_wb_idx = 5'h0;
    reg [3:0] i_reg_addr = 4'h0, c;
    reg [2:0] rd_sel = 3'h0;
    reg [63:0] m, d;
    reg mis;
    wire [31:0] o_reg_rdata, o_operand_a, o_operand_b, o_set_upper_value, o_target, o_mem_addr;
    wire [63:0] o_mem_wdata, mem_q;
    wire [7:0] o_mem_asi, o_mem_byte_en, o_fetch_asi;
    wire o_dec_valid, o_is_call, o_is_int_branch, o_is_float_branch, o_is_cop_branch, o_is_set_upper;
    wire o_is_unimpl_trap, o_is_undefined, o_annul_next, o_rd_write, o_mem_req, o_mem_we;
    wire o_misalign_trap, o_priv_trap, o_fetch_misalign;
    integer mismatches = 0, n_tests = 0, i, j, sz, nb;
    ifd_decode uut (.*, .o_format_sel(), .o_fmt2_sub_code(), .o_fmt3_func_code(), .o_operate_code(),
        .o_rd_index(), .o_src_one_index(), .o_src_two_index(), .o_branch_cond(), .o_is_alu(), .o_is_mem());
    ifd_mem_model u_mem (.i_clk, .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
        .i_be(o_mem_byte_en), .i_wdata(o_mem_wdata), .i_raddr(rd_sel), .o_dword(mem_q));
    // 50 MHz clock
    always #10 i_clk = ~i_clk;
    task wb(input [4:0] x, input [31:0] v);
        begin
            @(posedge i_clk) begin i_wb_en <= 1'h1; i_wb_idx <= x; i_wb_data <= v; end
            @(posedge i_clk) i_wb_en <= 1'h0;
            if (x != 5'h0) rv[x[2:0]] = v;
        end
    endtask
    // register access, data looked at next cycle
    task regio(input we, input [3:0] ad, input [31:0] v);
        begin
            @(posedge i_clk) begin i_reg_we <= we; i_reg_re <= !we; i_reg_addr <= ad; i_reg_wdata <= v; end
            @(posedge i_clk) begin i_reg_we <= 1'h0; i_reg_re <= 1'h0; end
            #1;
        end
    endtask
    // one word, two-cycle decode; words never rewritten
    task issue(input [31:0] ins, input [31:0] pc, input ct);
        begin
            @(posedge i_clk) begin i_instr_valid <= 1'h1; i_instr <= ins; i_pc <= pc; i_cond_true <= ct; end
            @(posedge i_clk) i_instr_valid <= 1'h0;
            @(posedge i_clk) #1;
            `CHK("dec_valid", 1'h1, o_dec_valid)
        end
    endtask
    function [63:0] lm(input [7:0] b);
        integer k;
        for (k = 0; k < 8; k = k + 1) lm[8*k +: 8] = {8{b[k]}};
    endfunction
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // watchdog, far beyond the sequence
    initial begin
        #200000;
        mismatches = mismatches + 1;
        end_sim;
    end
    initial begin
        i = $urandom(32'h86d0);
        rv[0] = 32'h0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'h1;
        #1 `CHK("fetch_asi", `IFD_ASI_UINSTR, o_fetch_asi)
        regio(1'h0, `IFD_OFS_CTRL, 32'h0);
        `CHK("ctrl", {30'h0, `IFD_CTRL_RST}, o_reg_rdata)
        regio(1'h0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, o_reg_rdata)
        for (i = 0; i < 8; i = i + 1) wb(i[4:0], (i == 1) ? $urandom & 32'hFFFF_FFC0 : $urandom);
        // register or immediate operand, index zero as source and destination
        for (i = 0; i < 8; i = i + 1) begin
            j = $urandom;
            w = {2'h2, 2'h0, i[2:0], 6'h00, 2'h0, i[2:0], j[13:5], 2'h0, j[2:0]};
            issue(w, 32'h0, 1'h0);
            `CHK("opa", rv[i], o_operand_a)
            `CHK("opb", j[13] ? {{19{w[12]}}, w[12:0]} : rv[j[2:0]], o_operand_b)
            `CHK("rd_write", i != 0, o_rd_write)
        end
        // all sizes and offsets, stores via the model
        for (sz = 0; sz < 4; sz = sz + 1)
            for (j = 0; j < 8; j = j + 1) begin
                w = {2'h3, (sz == 3) ? 5'h2 : 5'h4, 3'h0, 1'h1, sz[1:0], 5'h1, 1'h1, 10'h0, j[2:0]};
                a = rv[1] + j;
                nb = (sz == 1) ? 1 : (sz == 2) ? 2 : (sz == 0) ? 4 : 8;
                mis = (a[2:0] % nb) != 0;
                issue(w, 32'h100, 1'h0);
                `CHK("misalign", mis, o_misalign_trap)
                `CHK("mem_req", !mis, o_mem_req)
                if (!mis) begin
                    `CHK("addr", a, o_mem_addr)
                    `CHK("data_asi", `IFD_ASI_UDATA, o_mem_asi)
                    m = lm((8'hFF << (8 - nb)) >> a[2:0]);
                    `CHK("byte_en", (8'hFF << (8 - nb)) >> a[2:0], o_mem_byte_en)
                    d = ((sz == 3) ? {rv[2], rv[3]} : {32'h0, rv[4]}) << (64 - 8 * nb - 8 * j);
                    rd_sel = a[5:3];
                    @(posedge i_clk) #1;
                    `CHK("mem", d & m, mem_q & m)
                end
            end
        // user, supervisor: tags, alt space, fetch align
        for (i = 0; i < 2; i = i + 1) begin
            regio(1'h1, `IFD_OFS_CTRL, {30'h0, 1'h1, i[0]});
            @(posedge i_clk) #1;
            `CHK("fetch_asi", i ? `IFD_ASI_SINSTR : `IFD_ASI_UINSTR, o_fetch_asi)
            issue({2'h3, 5'h4, 6'h00, 5'h1, 1'h1, 13'h0}, 32'h200, 1'h0);
            `CHK("data_asi", i ? `IFD_ASI_SDATA : `IFD_ASI_UDATA, o_mem_asi)
            issue({2'h3, 5'h4, 6'h10, 5'h1, 1'h0, 8'h5A, 5'h0}, 32'h204, 1'h0);
            `CHK("priv_trap", !i[0], o_priv_trap)
            if (i) `CHK("alt_asi", 8'h5A, o_mem_asi)
            issue({2'h3, 5'h4, 6'h00, 5'h1, 1'h1, 13'h0}, 32'h202, 1'h0);
            `CHK("fetch_mis", 2'h2, {o_fetch_misalign, o_mem_req})
        end
        regio(1'h0, `IFD_OFS_LAST, 32'h0);
        `CHK("last", i_instr, o_reg_rdata)
        // annul table over bit, taken, never/always/conditional
        for (i = 0; i < 16; i = i + 1) begin
            j = $urandom;
            c = (i[3:2] == 0) ? 4'h0 : (i[3:2] == 1) ? 4'h8 : {j[31], (j[30:28] == 0) ? 3'h5 : j[30:28]};
            issue({2'h0, i[0], c, `IFD_SUB_IBR, j[21:0]}, 32'h4000, i[1]);
            `CHK("annul", i[0] & (c[2:0] == 0 | !i[1]), o_annul_next)
            `CHK("br_target", 32'h4000 + {{8{j[21]}}, j[21:0], 2'h0}, o_target)
        end
        // every branch-format sub code
        for (i = 0; i < 8; i = i + 1) begin
            j = $urandom;
            issue({2'h0, 5'h3, i[2:0], j[21:0]}, 32'h0, 1'h0);
            `CHK("kinds", {i == 0, i == 2, i == 4, i == 6, i == 7, i % 2 == 1 && i < 7}, {o_is_unimpl_trap,
                o_is_int_branch, o_is_set_upper, o_is_float_branch, o_is_cop_branch, o_is_undefined})
            if (i == 4) `CHK("upper", {j[21:0], 10'h000}, o_set_upper_value)
        end
        j = $urandom;
        issue({2'h1, j[29:0]}, 32'h8000_0000, 1'h0);
        `CHK("call", 32'h8000_0000 + {j[29:0], 2'h0}, o_target)
        end_sim;
    end
endmodule
